/* File: pkg/rcp_pkg.sv */
// Purpose: Shared types and constants for the channel power sequencer
// Assumes: 125 MHz clock, four channels in two pairs
// Notes:   Times are kept in their own units; cycle counts derive from them

`default_nettype none

package rcp_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int DET_INTERVAL_MS = 6;
  localparam int IDLE_WAIT_US = 10;
  // Fixed repeat interval, rounded down; scaled to ns to stay inside int
  localparam int DET_INTERVAL_CYC =
    (DET_INTERVAL_MS * 1000000) / (CLK_PERIOD_PS / 1000);
  // Least idle time before detection, rounded up
  localparam int IDLE_WAIT_CYC =
    (IDLE_WAIT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ==========================================================
  // Register map, byte addresses
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATE = 4'h4;
  localparam logic [ADDR_W-1:0] REG_SETTING = 4'h8;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // ==========================================================
  // Channel types
  typedef enum logic [1:0] {PS_OFF, PS_UNPLUG, PS_SLUMBER, PS_ACTIVE}
    rcp_pstate_e;
  // Pin level as reported by the four-level comparator
  typedef enum logic [1:0] {LV_LOW, LV_RES, LV_OPEN, LV_HIGH} rcp_level_e;
  typedef enum logic [1:0] {RX_PULL_GND, RX_HIZ, RX_TERM} rcp_rxterm_e;
  typedef enum logic [1:0] {TX_HIZ, TX_PULL_VDD, TX_TERM} rcp_txterm_e;

  // Pin sync reset values: enables default on, selects default open
  localparam logic SYNC_EN_RESET = 1'b1;
  localparam logic [1:0] SEL_RESET = 2'h2;
  // Decoded index reset values match the open setting
  localparam logic [1:0] BOOST_RESET = 2'h1;
  localparam logic [1:0] GAIN_RESET = 2'h2;

  typedef struct packed {
    rcp_pstate_e state;
    logic power_down_state;
    rcp_rxterm_e rx_term;
    rcp_txterm_e tx_term;
    logic sigdet_en;
    logic rxdet_req;
    logic [1:0] boost;
    logic [1:0] gain;
    logic setting_new;
  } rcp_chan_out_s;

  typedef struct packed {
    logic sig_active;
    logic det_done;
    logic det_load;
    logic [1:0] boost_sel;
    logic [1:0] gain_sel;
  } rcp_chan_in_s;

endpackage : rcp_pkg

`default_nettype wire

/* File: rtl/rcp_channel.sv */
// Purpose: One channel's power state machine and select decode
// Assumes: All inputs already synchronised to clk
// Notes:   Detector request is a four-phase handshake with det_done

`timescale 1ns/1ps
`default_nettype none

module rcp_channel
  import rcp_pkg::*;
#(
  parameter int IDLE_CYC = IDLE_WAIT_CYC,
  parameter int INTERVAL_CYC = DET_INTERVAL_CYC,
  parameter int CNT_W = $clog2(INTERVAL_CYC + 1)
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control
  input wire logic pair_en,
  input wire logic force_off,
  input wire rcp_chan_in_s ch_in,
  // Channel outputs
  output rcp_chan_out_s ch_out
);

  rcp_chan_out_s next_out;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic run;

  assign run = pair_en && !force_off;

  // ==========================================================
  // State machine
  always_comb
  begin
    next_out = ch_out;
    next_cnt = cnt;
    next_out.setting_new = 1'b0;
    if (!run)
    begin
      next_out.state = PS_OFF;
      next_out.rxdet_req = 1'b0;
      next_cnt = '0;
    end
    else
    begin
      unique case (ch_out.state)
        PS_OFF:
        begin
          next_out.state = PS_ACTIVE;
        end
        PS_ACTIVE:
        begin
          if (!ch_in.sig_active)
          begin
            next_out.state = PS_SLUMBER;
            next_cnt = CNT_W'(IDLE_CYC - 1);
          end
        end
        PS_SLUMBER:
        begin
          if (ch_in.sig_active)
          begin
            next_out.state = PS_ACTIVE;
            next_out.rxdet_req = 1'b0;
          end
          else if (ch_out.rxdet_req)
          begin
            if (ch_in.det_done)
            begin
              next_out.rxdet_req = 1'b0;
              if (!ch_in.det_load)
                next_out.state = PS_UNPLUG;
              else
                next_cnt = CNT_W'(INTERVAL_CYC - 1);
            end
          end
          else if (!ch_in.det_done)
          begin
            if (cnt == '0)
              next_out.rxdet_req = 1'b1;
            else
              next_cnt = cnt - 1'b1;
          end
        end
        PS_UNPLUG:
        begin
          if (ch_out.rxdet_req)
          begin
            if (ch_in.det_done)
            begin
              next_out.rxdet_req = 1'b0;
              if (ch_in.det_load)
              begin
                next_out.state = PS_SLUMBER;
                next_cnt = CNT_W'(INTERVAL_CYC - 1);
              end
            end
          end
          else if (!ch_in.det_done)
            next_out.rxdet_req = 1'b1;
        end
      endcase
    end
    // Terminations follow the state being entered
    unique case (next_out.state)
      PS_OFF:
      begin
        next_out.rx_term = RX_PULL_GND;
        next_out.tx_term = TX_HIZ;
      end
      PS_UNPLUG:
      begin
        next_out.rx_term = RX_HIZ;
        next_out.tx_term = TX_PULL_VDD;
      end
      PS_SLUMBER:
      begin
        next_out.rx_term = RX_TERM;
        next_out.tx_term = TX_PULL_VDD;
      end
      PS_ACTIVE:
      begin
        next_out.rx_term = RX_TERM;
        next_out.tx_term = TX_TERM;
      end
    endcase
    next_out.power_down_state = (next_out.state == PS_OFF);
    next_out.sigdet_en = (next_out.state != PS_OFF);
    // Select pins only count while the pair runs
    if (pair_en)
    begin
      unique case (rcp_level_e'(ch_in.boost_sel))
        LV_RES: next_out.boost = 2'h0;
        LV_OPEN: next_out.boost = 2'h1;
        LV_LOW: next_out.boost = 2'h2;
        LV_HIGH: next_out.boost = 2'h3;
      endcase
      next_out.gain = ch_in.gain_sel;
      next_out.setting_new = (next_out.boost != ch_out.boost) ||
        (next_out.gain != ch_out.gain);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ch_out <= '{PS_OFF, 1'b1, RX_PULL_GND, TX_HIZ, 1'b0, 1'b0,
                 BOOST_RESET, GAIN_RESET, 1'b0};
      cnt <= '0;
    end
    else
    begin
      ch_out <= next_out;
      cnt <= next_cnt;
    end
  end

  // ==========================================================
  // Checks
  if (IDLE_CYC < 5 || INTERVAL_CYC < 5 || INTERVAL_CYC >= 2**CNT_W ||
      IDLE_CYC >= 2**CNT_W)
  begin : g_bad_timer
    $error("rcp_channel: timer parameters out of range");
  end

  a_off_when_disabled: assert property (@(posedge clk) disable iff (!reset_n)
    !run |=> ch_out.state == PS_OFF && ch_out.power_down_state)
    else $error("channel not off while disabled");
  a_pd_termination: assert property (@(posedge clk) disable iff (!reset_n)
    ch_out.state == PS_OFF |-> ch_out.rx_term == RX_PULL_GND &&
    ch_out.tx_term == TX_HIZ && !ch_out.sigdet_en)
    else $error("power-down termination wrong");
  a_idle_to_slumber: assert property (@(posedge clk) disable iff (!reset_n)
    run && ch_out.state == PS_ACTIVE && !ch_in.sig_active
    |=> ch_out.state == PS_SLUMBER)
    else $error("idle channel did not enter slumber");
  a_slumber_sigdet: assert property (@(posedge clk) disable iff (!reset_n)
    ch_out.state == PS_SLUMBER |-> ch_out.sigdet_en &&
    ch_out.tx_term == TX_PULL_VDD)
    else $error("slumber detector or output wrong");
  a_wake_active: assert property (@(posedge clk) disable iff (!reset_n)
    run && ch_out.state == PS_SLUMBER && ch_in.sig_active
    |=> ch_out.state == PS_ACTIVE && ch_out.rx_term == RX_TERM &&
    ch_out.tx_term == TX_TERM)
    else $error("activity did not wake channel");
  a_noload_unplug: assert property (@(posedge clk) disable iff (!reset_n)
    run && ch_out.state == PS_SLUMBER && !ch_in.sig_active &&
    ch_out.rxdet_req && ch_in.det_done && !ch_in.det_load
    |=> ch_out.state == PS_UNPLUG ##1 ch_out.rx_term == RX_HIZ)
    else $error("missing load did not unplug");
  a_load_back_slumber: assert property (@(posedge clk)
    disable iff (!reset_n)
    run && ch_out.state == PS_UNPLUG && ch_out.rxdet_req &&
    ch_in.det_done && ch_in.det_load
    |=> ch_out.state == PS_SLUMBER && !ch_out.rxdet_req [*4])
    else $error("load found but no slumber wait");
  a_idle_wait: assert property (@(posedge clk) disable iff (!reset_n)
    ch_out.state == PS_ACTIVE ##1 ch_out.state == PS_SLUMBER
    |-> !ch_out.rxdet_req [*5])
    else $error("detection started before idle wait");
  a_select_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !pair_en |=> $stable(ch_out.boost) && $stable(ch_out.gain))
    else $error("select changed while pair disabled");
  a_boost_open: assert property (@(posedge clk) disable iff (!reset_n)
    pair_en && ch_in.boost_sel == LV_OPEN |=> ch_out.boost == 2'h1)
    else $error("open boost level decoded wrong");

  c_unplug: cover property (@(posedge clk) disable iff (!reset_n)
    ch_out.state == PS_UNPLUG);
  c_replug: cover property (@(posedge clk) disable iff (!reset_n)
    ch_out.state == PS_UNPLUG ##1 ch_out.state == PS_SLUMBER);
  c_wake: cover property (@(posedge clk) disable iff (!reset_n)
    ch_out.state == PS_SLUMBER ##1 ch_out.state == PS_ACTIVE);

endmodule : rcp_channel

`default_nettype wire

/* File: rtl/rcp_top.sv */
// Purpose: Four-channel power sequencer with AXI4-Lite status and control
// Assumes: Detector and select comparator results arrive asynchronously
// Notes:   Functional notes below
//
// Functional notes
// - One enable per pair; 1 enables, 0 disables, default enabled.
// - Enable low holds both pair channels off; high runs each one whose force_off bit is clear.
// - A channel whose signal detector reports idle enters slumber.
// - Each channel decides its own transitions independently.
// - Signal detector stays enabled and monitoring during slumber.
// - During slumber the channel runs far-end receiver detection.
// - No load found: enter unplug and keep checking for a load.
// - Load found in unplug: back to slumber, redetect every 6 ms.
// - Off state: weak input pull to ground, output high impedance.
// - Unplug and slumber: weak output pull up; unplug input Hi-Z.
// - Boost select decodes four levels to four strengths; open default.
// - Gain select decodes four levels to four gains; open default.
// - Receiver detection starts only after a set idle period.

`timescale 1ns/1ps
`default_nettype none

module rcp_top
  import rcp_pkg::*;
#(
  parameter int NUM_CH = 4,
  parameter int IDLE_CYC = IDLE_WAIT_CYC,
  parameter int INTERVAL_CYC = DET_INTERVAL_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Pair enables
  input wire logic first_pair_enable,
  input wire logic second_pair_enable,
  // Analog detector results, one bit per channel
  input wire logic [NUM_CH-1:0] sig_active,
  input wire logic [NUM_CH-1:0] rxdet_done,
  input wire logic [NUM_CH-1:0] rxdet_load,
  // Four-level select comparator results
  input wire logic [1:0] lane_a_boost_select,
  input wire logic [1:0] lane_b_boost_select,
  input wire logic [1:0] lane_c_boost_select,
  input wire logic [1:0] lane_d_boost_select,
  input wire logic [1:0] lane_a_gain_select,
  input wire logic [1:0] lane_b_gain_select,
  input wire logic [1:0] lane_c_gain_select,
  input wire logic [1:0] lane_d_gain_select,
  // Channel controls
  output rcp_chan_out_s [NUM_CH-1:0] chan_out,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int SYNC_W = 2 + 3 * NUM_CH + 4 * NUM_CH;
  // Activity reads as present through reset, so no false idle follows it
  localparam logic [SYNC_W-1:0] SYNC_RESET =
    {{NUM_CH{SEL_RESET}}, {NUM_CH{SEL_RESET}}, {(2 * NUM_CH){1'b0}},
     {NUM_CH{1'b1}}, {2{SYNC_EN_RESET}}};

  if (NUM_CH != 4)
  begin : g_bad_count
    $error("rcp_top: exactly four channels in two pairs are supported");
  end

  // ==========================================================
  // Input synchroniser
  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] sync_meta;
  logic [SYNC_W-1:0] sync_in;

  assign raw_in = {lane_d_gain_select, lane_c_gain_select,
                   lane_b_gain_select, lane_a_gain_select,
                   lane_d_boost_select, lane_c_boost_select,
                   lane_b_boost_select, lane_a_boost_select,
                   rxdet_load, rxdet_done, sig_active,
                   second_pair_enable, first_pair_enable};

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      // Enables read as on through reset, as an open pin does
      sync_meta <= SYNC_RESET;
      sync_in <= SYNC_RESET;
    end
    else
    begin
      sync_meta <= raw_in;
      sync_in <= sync_meta;
    end
  end

  logic [1:0] pair_en;
  logic [NUM_CH-1:0] act_s;
  logic [NUM_CH-1:0] done_s;
  logic [NUM_CH-1:0] load_s;
  logic [2*NUM_CH-1:0] boost_s;
  logic [2*NUM_CH-1:0] gain_s;

  assign {gain_s, boost_s, load_s, done_s, act_s, pair_en} = sync_in;

  // ==========================================================
  // Channels
  logic [3:0] force_off;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_chan
      rcp_chan_in_s ci;
      assign ci = '{act_s[g], done_s[g], load_s[g],
                    boost_s[2*g+1:2*g], gain_s[2*g+1:2*g]};
      // Channels 0,1 share the first enable, 2,3 the second
      rcp_channel #(
        .IDLE_CYC(IDLE_CYC),
        .INTERVAL_CYC(INTERVAL_CYC)
      ) u_chan (
        .clk(clk),
        .reset_n(reset_n),
        .pair_en(pair_en[g/2]),
        .force_off(force_off[g]),
        .ch_in(ci),
        .ch_out(chan_out[g])
      );
    end
  endgenerate

  // ==========================================================
  // AXI4-Lite slave
  logic aw_hold;
  logic next_aw_hold;
  logic [ADDR_W-1:0] aw_addr;
  logic [ADDR_W-1:0] next_aw_addr;
  logic w_hold;
  logic next_w_hold;
  logic [31:0] w_data;
  logic [31:0] next_w_data;
  logic [3:0] w_strb;
  logic [3:0] next_w_strb;
  logic [3:0] next_force_off;
  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_arready;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic [31:0] state_word;
  logic [31:0] setting_word;

  always_comb
  begin
    state_word = '0;
    setting_word = '0;
    for (int i = 0; i < NUM_CH; i++)
    begin
      state_word[2*i +: 2] = chan_out[i].state;
      state_word[8 + i] = chan_out[i].rxdet_req;
      setting_word[2*i +: 2] = chan_out[i].boost;
      setting_word[8 + 2*i +: 2] = chan_out[i].gain;
    end
    state_word[13:12] = pair_en;
  end

  always_comb
  begin
    next_aw_hold = aw_hold;
    next_aw_addr = aw_addr;
    next_w_hold = w_hold;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_force_off = force_off;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_hold = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_hold = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    // Write commits once both halves are held and no response pends
    if (aw_hold && w_hold && !s_axi_bvalid)
    begin
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = AXI_SLVERR;
      if (aw_addr == REG_CTRL)
      begin
        next_bresp = AXI_OKAY;
        if (w_strb[0])
          next_force_off = w_data[3:0];
      end
    end
    if (s_axi_rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp = AXI_OKAY;
      unique case (s_axi_araddr)
        REG_CTRL: next_rdata = {28'h0000000, force_off};
        REG_STATE: next_rdata = state_word;
        REG_SETTING: next_rdata = setting_word;
        default:
        begin
          next_rdata = '0;
          next_rresp = AXI_SLVERR;
        end
      endcase
    end
    next_awready = !next_aw_hold && !next_bvalid;
    next_wready = !next_w_hold && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      aw_hold <= 1'b0;
      aw_addr <= '0;
      w_hold <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      force_off <= CTRL_RESET;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= AXI_OKAY;
    end
    else
    begin
      aw_hold <= next_aw_hold;
      aw_addr <= next_aw_addr;
      w_hold <= next_w_hold;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      force_off <= next_force_off;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // ==========================================================
  // Checks
  a_pair_shared_off: assert property (@(posedge clk) disable iff (!reset_n)
    !pair_en[0] |=> chan_out[0].state == PS_OFF &&
    chan_out[1].state == PS_OFF)
    else $error("first pair not off while disabled");
  a_chan_independent: assert property (@(posedge clk)
    disable iff (!reset_n)
    pair_en[0] && !force_off[0] && !force_off[1] &&
    chan_out[0].state == PS_ACTIVE && chan_out[1].state == PS_ACTIVE &&
    !act_s[0] && act_s[1]
    |=> chan_out[0].state == PS_SLUMBER &&
    chan_out[1].state == PS_ACTIVE)
    else $error("channels of a pair did not act independently");
  a_gain_open: assert property (@(posedge clk) disable iff (!reset_n)
    pair_en[1] && gain_s[5:4] == LV_OPEN |=> chan_out[2].gain == 2'h2)
    else $error("open gain level decoded wrong");

  c_write_ctrl: cover property (@(posedge clk) disable iff (!reset_n)
    s_axi_bvalid && s_axi_bresp == AXI_OKAY);
  c_split_state: cover property (@(posedge clk) disable iff (!reset_n)
    chan_out[0].state == PS_SLUMBER && chan_out[1].state == PS_ACTIVE);

endmodule : rcp_top

`default_nettype wire

/* File: dv/rcp_far_end.sv */
// Purpose: Far-end receiver model answering detection requests
// Assumes: A request is a level held until done is seen
// Notes:   Load result toggles outside done, as it is undriven then

`timescale 1ns/1ps
`default_nettype none

module rcp_far_end
#(
  parameter int DLY = 3
)
(
  // Clock
  input wire logic clk,
  // Detection link
  input wire logic [3:0] req,
  input wire logic [3:0] load_on,
  output logic [3:0] done,
  output logic [3:0] load
);
  // ==========================================================
  // Response
  int cnt [4] = '{default: 0};
  logic tgl = 1'h0;

  initial done = 4'h0;

  always @(posedge clk)
  begin
    tgl <= ~tgl;
    for (int i = 0; i < 4; i++)
    begin
      cnt[i] <= req[i] ? cnt[i] + 1 : 0;
      done[i] <= req[i] && cnt[i] >= DLY;
    end
  end

  // Result is only meaningful while done is up
  always @*
    for (int i = 0; i < 4; i++)
      load[i] = done[i] ? load_on[i] : tgl;

endmodule : rcp_far_end

`default_nettype wire

/* File: dv/test_redriver_channel_power_fsm.sv */
// Purpose: Directed bench for the channel power sequencer
// Assumes: Short idle and interval counts so the run stays brief
// Notes:   Outputs are read right after an edge, before it lands

`timescale 1ns/1ps
`default_nettype none

module test_redriver_channel_power_fsm import rcp_pkg::*;;
  // ==========================================================
  // Signals
  logic clk = 1'h0, reset_n = 1'h0, en_a = 1'h1, en_b = 1'h1;
  logic [3:0] sig = 4'hF, done, load, load_on = 4'hF;
  logic [1:0] bsel [4] = '{default: 2'h2};
  logic [1:0] gsel [4] = '{default: 2'h2};
  logic [1:0] bmap [4] = '{2'h2, 2'h0, 2'h1, 2'h3};
  rcp_chan_out_s [3:0] co;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rd, dat;
  logic awv = 1'h0, wv = 1'h0, brd = 1'h0, arv = 1'h0, rrd = 1'h0;
  logic awr, wr, arr, bv, rv;
  logic [1:0] br, rr, resp;
  int error_cnt = 0, cmp_count = 0, cyc = 0, n;
  int new_cnt [4] = '{default: 0};

  always #4 clk = ~clk;

  rcp_top #(.IDLE_CYC(8), .INTERVAL_CYC(20)) dut_u (
    .clk(clk), .reset_n(reset_n),
    .first_pair_enable(en_a), .second_pair_enable(en_b),
    .sig_active(sig), .rxdet_done(done), .rxdet_load(load),
    .lane_a_boost_select(bsel[0]), .lane_b_boost_select(bsel[1]),
    .lane_c_boost_select(bsel[2]), .lane_d_boost_select(bsel[3]),
    .lane_a_gain_select(gsel[0]), .lane_b_gain_select(gsel[1]),
    .lane_c_gain_select(gsel[2]), .lane_d_gain_select(gsel[3]),
    .chan_out(co),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(brd), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rrd));

  rcp_far_end far_u (.clk(clk), .load_on(load_on), .done(done),
    .load(load), .req({co[3].rxdet_req, co[2].rxdet_req,
    co[1].rxdet_req, co[0].rxdet_req}));

  // ==========================================================
  // Tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask : chk

  task finish_test();
    $display("mismatches %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  task ticks(input int k);
    repeat (k) @(posedge clk);
  endtask : ticks

  task axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    brd <= 1'h1;
    while (bv !== 1'h1)
    begin
      @(posedge clk);
      if (awr) awv <= 1'h0;
      if (wr) wv <= 1'h0;
    end
    resp = br;
    brd <= 1'h0;
  endtask : axi_wr

  task axi_rd(input logic [3:0] a);
    @(posedge clk);
    araddr <= a;
    arv <= 1'h1;
    rrd <= 1'h1;
    while (rv !== 1'h1)
    begin
      @(posedge clk);
      if (arr) arv <= 1'h0;
    end
    resp = rr;
    dat = rd;
    rrd <= 1'h0;
  endtask : axi_rd

  // Bounded wait for a state, then compare
  task wait_st(input int ch, input rcp_pstate_e st);
    for (int k = 0; k < 100 && co[ch].state !== st; k++)
      @(posedge clk);
    chk(co[ch].state, st);
  endtask : wait_st

  // Edges until the channel raises its detection request
  task count_req(input int ch);
    for (n = 0; n < 60 && co[ch].rxdet_req !== 1'h1; n++)
      @(posedge clk);
  endtask : count_req

  // Pulses of the new-setting flag, per channel
  always @(posedge clk)
    for (int i = 0; i < 4; i++)
      if (co[i].setting_new === 1'h1)
        new_cnt[i] <= new_cnt[i] + 1;

  // ==========================================================
  // Timeout
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      error_cnt++;
      finish_test();
    end
  end

  // ==========================================================
  // Sequence
  initial
  begin
    repeat (20) @(posedge clk);
    chk({co[0].state, co[0].power_down_state}, 3'h1);
    reset_n <= 1'h1;
    ticks(5);
    for (int i = 0; i < 4; i++)
    begin
      chk(co[i].state, PS_ACTIVE);
      chk({co[i].rx_term, co[i].tx_term}, {RX_TERM, TX_TERM});
    end
    for (int lv = 0; lv < 4; lv++)
    begin
      bsel[0] <= lv[1:0];
      gsel[1] <= lv[1:0];
      ticks(5);
      chk(co[0].boost, bmap[lv]);
      chk(co[1].gain, lv[1:0]);
      chk({co[1].boost, co[0].gain}, 4'h6);
    end
    chk(new_cnt[0], 32'h4);
    chk(new_cnt[1], 32'h4);
    chk(new_cnt[2] + new_cnt[3], 32'h0);
    axi_rd(REG_SETTING);
    chk(dat, 32'h0000AE57);
    bsel[0] <= 2'h2;
    gsel[1] <= 2'h2;
    en_a <= 1'h0;
    ticks(6);
    bsel[1] <= 2'h3;
    ticks(5);
    chk(co[0].state, PS_OFF);
    chk({co[1].power_down_state, co[1].rx_term, co[1].tx_term},
      {1'h1, RX_PULL_GND, TX_HIZ});
    chk(co[1].boost, 2'h1);
    chk(co[2].state, PS_ACTIVE);
    axi_rd(REG_STATE);
    chk(dat & 32'hFF, 32'hF0);
    en_a <= 1'h1;
    bsel[1] <= 2'h2;
    ticks(6);
    chk(co[0].state, PS_ACTIVE);
    load_on <= 4'hB;
    sig[2] <= 1'h0;
    wait_st(2, PS_SLUMBER);
    chk({co[2].sigdet_en, co[2].tx_term}, {1'h1, TX_PULL_VDD});
    chk(co[3].state, PS_ACTIVE);
    count_req(2);
    chk(n >= 6 && n <= 10, 1'h1);
    wait_st(2, PS_UNPLUG);
    chk(co[2].rx_term, RX_HIZ);
    count_req(2);
    chk(n <= 15, 1'h1);
    load_on <= 4'hF;
    wait_st(2, PS_SLUMBER);
    count_req(2);
    chk(n >= 16 && n <= 26, 1'h1);
    sig[2] <= 1'h1;
    wait_st(2, PS_ACTIVE);
    chk({co[2].rx_term, co[2].tx_term}, {RX_TERM, TX_TERM});
    axi_wr(REG_CTRL, 32'h8);
    chk(resp, AXI_OKAY);
    ticks(3);
    chk(co[3].state, PS_OFF);
    axi_rd(REG_CTRL);
    chk(dat, 32'h8);
    axi_wr(REG_CTRL, 32'h0);
    ticks(3);
    chk(co[3].state, PS_ACTIVE);
    axi_wr(REG_STATE, 32'hF);
    chk(resp, AXI_SLVERR);
    axi_rd(4'hC);
    chk(resp, AXI_SLVERR);
    chk(dat, 32'h0);
    finish_test();
  end

endmodule : test_redriver_channel_power_fsm

`default_nettype wire
